// ### pemsk_pkg.sv
// Constants for the power event interrupt mask and control register block
package pemsk_pkg;

  // Register location and widths
  localparam logic [7:0] PEMSK_CTRL_ADDR  = 8'h06;
  localparam int         PEMSK_DATA_W     = 8;
  localparam logic [7:0] PEMSK_CTRL_RESET = 8'h00;
  localparam logic [7:0] PEMSK_CTRL_MASK  = 8'h3E;
  localparam logic [7:0] PEMSK_RD_NONE    = 8'h00;

  // Field positions inside the control register
  localparam int PEMSK_EXTPWR_BIT = 5;
  localparam int PEMSK_HOSTPWR_BIT = 4;
  localparam int PEMSK_ILIM_BIT   = 3;
  localparam int PEMSK_BROWN_BIT  = 2;
  localparam int PEMSK_STEPUP_BIT = 1;

  // Event source positions in the change detector vector
  localparam int PEMSK_SRC_W      = 8;
  localparam int PEMSK_SRC_USB    = 0;
  localparam int PEMSK_SRC_WALL   = 1;
  localparam int PEMSK_SRC_EXT    = 2;
  localparam int PEMSK_SRC_RUN    = 3;
  localparam int PEMSK_SRC_ID     = 4;
  localparam int PEMSK_SRC_ILIM   = 5;
  localparam int PEMSK_SRC_BROWN  = 6;
  localparam int PEMSK_SRC_HOT    = 7;

  // Address decode, shared by the read and the write path
  function automatic logic pemsk_hit(input logic [7:0] addr);
    pemsk_hit = (addr == PEMSK_CTRL_ADDR);
  endfunction : pemsk_hit

endpackage : pemsk_pkg

// ### pemsk_change_det.sv
// Change detector: one-cycle flag per bit whenever a status input toggles
`timescale 1ns/100ps
module pemsk_change_det
  import pemsk_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // Status levels in, change flags out
  input  wire logic [PEMSK_SRC_W-1:0] sample,
  output logic      [PEMSK_SRC_W-1:0] change_q
);

  typedef struct packed {
    logic [PEMSK_SRC_W-1:0] prev;
    logic                   primed;
    logic [PEMSK_SRC_W-1:0] change;
  } pemsk_det_state_t;

  pemsk_det_state_t s_q;
  pemsk_det_state_t s_d;

  // First sample after reset only primes history, so reset is no event
  always_comb begin
    s_d        = s_q;
    s_d.prev   = sample;
    s_d.primed = 1'b1;
    s_d.change = s_q.primed ? (sample ^ s_q.prev) : '0;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign change_q = s_q.change;

endmodule : pemsk_change_det

// ### pemsk_power_event_mask.sv
// Interrupt enable and step-up control register with pending request latch
`timescale 1ns/100ps
module pemsk_power_event_mask
  import pemsk_pkg::*;
(
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Register port toward the serial host controller
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [PEMSK_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_rd,
  output logic      [PEMSK_DATA_W-1:0] reg_rdata_q,
  // Input power status
  input  wire logic                    usb_input_sense_good,
  input  wire logic                    wall_input_sense_good,
  input  wire logic                    external_power_good,
  input  wire logic                    usb_voltage_present,
  input  wire logic                    wall_voltage_present,
  input  wire logic                    input_current_limited,
  input  wire logic                    brownout_limiting_active,
  // Host power (step-up) status and setting
  input  wire logic                    step_up_running,
  input  wire logic                    otg_id_sensed,
  input  wire logic                    auto_step_up_lockout,
  // Thermistor comparators and overheat options
  input  wire logic                    thermistor_upper_limit,
  input  wire logic                    thermistor_lower_limit,
  input  wire logic                    thermistor_overheat_limit,
  input  wire logic                    overheat_irq_on,
  input  wire logic                    overheat_conditioner_on,
  // Control outputs
  output logic                         irq_pending_q,
  output logic                         step_up_enable_q,
  output logic                         charge_pause_q,
  output logic                         conditioner_enable_q
);

  // Behaviour overview
  //
  // The block owns one 8-bit control word at sub-address 0x06. Bits 5 to 2
  // are interrupt enables for four groups of status levels, bit 1 is the
  // manual step-up request, and bits 7, 6 and 0 are not stored here. They
  // read back as zero. A neighbouring register shares the sub-address in the
  // full device, so those positions are left alone on purpose.
  //
  // Interrupt path
  //   Every watched status level is sampled once per clock. A change flag
  //   is raised for one cycle whenever a sample differs from the previous
  //   one. The flags are grouped, each group is gated by its enable bit (overheat by overheat_irq_on), and
  //   any surviving trigger sets the pending request. That request stands
  //   until the host writes the control word again, whatever data it
  //   writes. A trigger in the very cycle of that write still sets the
  //   request, because losing an event is worse than one spare interrupt.
  //
  //   Changes seen while a group is disabled leave no trace. Turning an
  //   enable on later does not replay them; the host must read the status
  //   levels itself after enabling a group.
  //
  //   The first sample after reset only primes the change history, so the
  //   levels present when reset is released never count as an event.
  //
  // Step-up path
  //   The step-up enable follows either the manual request bit or the
  //   automatic request, which needs the id sense with the lockout
  //   released. Voltage on either input forces the enable low, whichever
  //   request is active; this check has the last word.
  //
  // Thermistor path
  //   Charging pauses while the temperature sits outside the window of the
  //   upper and lower comparators. The overheat comparator can raise an
  //   interrupt, turn on the battery conditioner, or both, each under its
  //   own option input.
  //
  // Every output comes straight from a register of the state struct, so the
  // controls lag their inputs by one clock; the pending request lags a status
  // change by two, since the change detector adds its own register stage.

  typedef struct packed {
    logic [PEMSK_DATA_W-1:0] ctrl;
    logic                    irq;
    logic                    step_up;
    logic                    pause;
    logic                    cond;
    logic [PEMSK_DATA_W-1:0] rdata;
  } pemsk_top_state_t;

  pemsk_top_state_t s_q;
  pemsk_top_state_t s_d;

  logic [PEMSK_SRC_W-1:0] status_vec;
  logic [PEMSK_SRC_W-1:0] changed;
  logic                   wr_hit;
  logic                   event_hit;
  logic                   auto_req;

  // Gather every watched status level into one vector
  always_comb begin
    status_vec                  = '0;
    status_vec[PEMSK_SRC_USB]   = usb_input_sense_good;
    status_vec[PEMSK_SRC_WALL]  = wall_input_sense_good;
    status_vec[PEMSK_SRC_EXT]   = external_power_good;
    status_vec[PEMSK_SRC_RUN]   = step_up_running;
    status_vec[PEMSK_SRC_ID]    = otg_id_sensed;
    status_vec[PEMSK_SRC_ILIM]  = input_current_limited;
    status_vec[PEMSK_SRC_BROWN] = brownout_limiting_active;
    status_vec[PEMSK_SRC_HOT]   = thermistor_overheat_limit;
  end

  pemsk_change_det u_change_det (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sample   (status_vec),
    .change_q (changed)
  );

  assign wr_hit = reg_wr && pemsk_hit(reg_addr);

  // Raw change of each source group, before its enable is applied
  logic chg_extpwr;
  logic chg_hostpwr;
  logic chg_ilim;
  logic chg_brown;
  logic chg_hot;

  // Group triggers after gating; kept apart so each can be probed alone
  logic fire_extpwr;
  logic fire_hostpwr;
  logic fire_ilim;
  logic fire_brown;
  logic fire_hot;

  // Collect the change flags of each group
  always_comb begin
    chg_extpwr  = changed[PEMSK_SRC_USB] || changed[PEMSK_SRC_WALL] ||
                  changed[PEMSK_SRC_EXT];
    chg_hostpwr = changed[PEMSK_SRC_RUN] || changed[PEMSK_SRC_ID];
    chg_ilim    = changed[PEMSK_SRC_ILIM];
    chg_brown   = changed[PEMSK_SRC_BROWN];
    chg_hot     = changed[PEMSK_SRC_HOT];
  end

  // Each source group is gated by its own enable bit, the overheat group by overheat_irq_on
  always_comb begin
    fire_extpwr  = s_q.ctrl[PEMSK_EXTPWR_BIT] && chg_extpwr;
    fire_hostpwr = s_q.ctrl[PEMSK_HOSTPWR_BIT] && chg_hostpwr;
    fire_ilim    = s_q.ctrl[PEMSK_ILIM_BIT] && chg_ilim;
    fire_brown   = s_q.ctrl[PEMSK_BROWN_BIT] && chg_brown;
    fire_hot     = overheat_irq_on && chg_hot;
    event_hit    = fire_extpwr || fire_hostpwr || fire_ilim ||
                   fire_brown || fire_hot;
  end

  // Automatic start only on id detection with the lockout released
  assign auto_req = otg_id_sensed && !auto_step_up_lockout;

  always_comb begin
    s_d = s_q;
    // Only the owned fields store; other bit positions read back as zero
    if (wr_hit) begin
      s_d.ctrl = reg_wdata & PEMSK_CTRL_MASK;
    end
    // Write acknowledges, but a same-cycle event still sets so none is lost
    if (event_hit) begin
      s_d.irq = 1'b1;
    end else if (wr_hit) begin
      s_d.irq = 1'b0;
    end
    // Input voltage overrides both manual and automatic requests
    s_d.step_up = (s_q.ctrl[PEMSK_STEPUP_BIT] || auto_req)
                  && !usb_voltage_present
                  && !wall_voltage_present;
    s_d.pause = thermistor_upper_limit || thermistor_lower_limit;
    s_d.cond  = thermistor_overheat_limit && overheat_conditioner_on;
    // Read data is registered; unmapped addresses answer zero
    if (reg_rd) begin
      s_d.rdata = pemsk_hit(reg_addr) ? s_q.ctrl : PEMSK_RD_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.ctrl  <= PEMSK_CTRL_RESET;
      s_q.rdata <= PEMSK_RD_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_q          = s_q.rdata;
  assign irq_pending_q        = s_q.irq;
  assign step_up_enable_q     = s_q.step_up;
  assign charge_pause_q       = s_q.pause;
  assign conditioner_enable_q = s_q.cond;

endmodule : pemsk_power_event_mask

// ### pemsk_chk.sv
// Assertions on the power event mask block ports
`timescale 1ns/100ps
module pemsk_chk
  import pemsk_pkg::*;
(
  // Watched ports
  input wire logic core_clk, resetn, reg_wr, reg_rd, irq_pending_q,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata_q,
  input wire logic usb_input_sense_good, wall_input_sense_good,
  input wire logic external_power_good, step_up_running, otg_id_sensed,
  input wire logic input_current_limited, brownout_limiting_active,
  input wire logic thermistor_overheat_limit, auto_step_up_lockout,
  input wire logic usb_voltage_present, wall_voltage_present,
  input wire logic step_up_enable_q, charge_pause_q,
  input wire logic thermistor_upper_limit, thermistor_lower_limit,
  input wire logic overheat_conditioner_on, conditioner_enable_q
);
  logic [7:0] ctrl_q, st_q, st, d;
  logic       hit, en_chg, auto_on;
  // Event levels; a toggle against the last edge counts as an event
  assign st = {usb_input_sense_good, wall_input_sense_good,
    external_power_good, step_up_running, otg_id_sensed,
    input_current_limited, brownout_limiting_active,
    thermistor_overheat_limit};
  assign d = st ^ st_q;
  assign hit = reg_addr == PEMSK_CTRL_ADDR;
  assign en_chg = (|d[7:5] & ctrl_q[5]) | (|d[4:3] & ctrl_q[4]) |
    (d[2] & ctrl_q[3]) | (d[1] & ctrl_q[2]);
  assign auto_on = !usb_voltage_present && !wall_voltage_present &&
    (ctrl_q[1] || otg_id_sensed && !auto_step_up_lockout);
  // Shadow register; unstored bits masked so reads compare cleanly
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) {ctrl_q, st_q} <= 16'h0000;
    else begin
      st_q <= st;
      if (reg_wr && hit) ctrl_q <= reg_wdata & PEMSK_CTRL_MASK;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Acknowledge write with no event already in flight
  sequence s_ack;
    reg_wr && hit && !$past(|d);
  endsequence
  sequence s_rise;
    !irq_pending_q ##1 irq_pending_q;
  endsequence
  chk_rd_data: assert property (reg_rd |=>
    reg_rdata_q == $past(hit ? ctrl_q : 8'h00)) else $error("bad read");
  chk_irq_set: assert property (en_chg |-> ##2 irq_pending_q)
    else $error("event lost");
  chk_irq_hold: assert property (irq_pending_q && !(reg_wr && hit)
    |=> irq_pending_q) else $error("pending dropped");
  chk_irq_ack: assert property (s_ack |=> !irq_pending_q)
    else $error("no clear");
  chk_irq_cause: assert property (s_rise |-> $past(|d, 2))
    else $error("pending without event");
  chk_step_block: assert property (usb_voltage_present ||
    wall_voltage_present |=> !step_up_enable_q) else $error("step-up on");
  chk_step_rule: assert property (step_up_enable_q == $past(auto_on))
    else $error("step-up wrong");
  chk_pause_rule: assert property (charge_pause_q ==
    $past(thermistor_upper_limit || thermistor_lower_limit))
    else $error("pause wrong");
  chk_cond_rule: assert property (conditioner_enable_q ==
    $past(thermistor_overheat_limit && overheat_conditioner_on))
    else $error("conditioner wrong");
endmodule : pemsk_chk
bind pemsk_power_event_mask pemsk_chk i_pemsk_chk (.*);

// ### pemsk_host.sv
// Host model driving the sub-address register port
`timescale 1ns/100ps
module pemsk_host (
  // Clock and register port
  input  wire logic       core_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
  // One strobe cycle; idle address is scrambled so no stale hit lingers
  task automatic xfer(logic w, logic [7:0] a, dt, output logic [7:0] q);
    @(posedge core_clk);
    {reg_addr, reg_wdata} <= {a, dt};
    {reg_wr, reg_rd} <= {w, !w};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'b00;
    {reg_addr, reg_wdata} <= ~{a, dt};
    @(posedge core_clk);
    #1 q = reg_rdata_q;
  endtask : xfer
endmodule : pemsk_host

// ### testbench.sv
// Testbench for the power event mask block
`timescale 1ns/100ps
module testbench;
  logic        clk = 0, rstn = 0, wr, rd, irq, su, cp, ce;
  logic [7:0]  a, w, r, q;
  logic [14:0] s = '0;
  int          failures = 0, total_checks = 0;
  always #2 clk = ~clk;
  pemsk_host i_pemsk_host (.core_clk(clk), .reg_addr(a), .reg_wr(wr),
    .reg_wdata(w), .reg_rd(rd), .reg_rdata_q(r));
  pemsk_power_event_mask i_pemsk_power_event_mask (.core_clk(clk),
    .resetn(rstn), .reg_addr(a), .reg_wr(wr), .reg_wdata(w), .reg_rd(rd),
    .reg_rdata_q(r), .usb_input_sense_good(s[0]),
    .wall_input_sense_good(s[1]), .external_power_good(s[2]),
    .step_up_running(s[3]), .otg_id_sensed(s[4]),
    .input_current_limited(s[5]), .brownout_limiting_active(s[6]),
    .thermistor_overheat_limit(s[7]), .usb_voltage_present(s[8]),
    .wall_voltage_present(s[9]), .auto_step_up_lockout(s[10]),
    .thermistor_upper_limit(s[11]), .thermistor_lower_limit(s[12]),
    .overheat_irq_on(s[13]), .overheat_conditioner_on(s[14]),
    .irq_pending_q(irq), .step_up_enable_q(su), .charge_pause_q(cp),
    .conditioner_enable_q(ce));
  task automatic chk(string n, logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // Level change lands at the next edge; three edges cover the latency
  task automatic put(int i, logic v);
    @(posedge clk) s[i] <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask : put
  task automatic wx(logic [7:0] ad, dt);
    i_pemsk_host.xfer(1'b1, ad, dt, q);
  endtask : wx
  task automatic rx(logic [7:0] ad, exp);
    i_pemsk_host.xfer(1'b0, ad, 8'h00, q);
    chk("rdata", q, exp);
  endtask : rx
  task automatic t_regs();
    rx(8'h06, 8'h00);
    wx(8'h06, 8'hFF);
    wx(8'h07, 8'h00);
    rx(8'h06, 8'h3E);
    rx(8'h07, 8'h00);
  endtask : t_regs
  task automatic t_irq();
    int eb[8] = '{5, 5, 5, 4, 4, 3, 2, 0};
    for (int i = 0; i < 8; i++) begin
      put(13, i == 7);
      wx(8'h06, 8'h01 << eb[i]);
      put(i, 1'b1);
      chk("irq set", irq, 8'h01);
      wx(8'h06, 8'h00);
      chk("irq ack", irq, 8'h00);
      put(13, 1'b0);
      put(i, 1'b0);
      chk("irq masked", irq, 8'h00);
    end
  endtask : t_irq
  task automatic t_step();
    wx(8'h06, 8'h02);
    put(8, 1'b1);
    chk("step usb", su, 8'h00);
    put(8, 1'b0);
    chk("step manual", su, 8'h01);
    put(9, 1'b1);
    chk("step wall", su, 8'h00);
    wx(8'h06, 8'h00);
    put(9, 1'b0);
    put(4, 1'b1);
    chk("step auto", su, 8'h01);
    put(10, 1'b1);
    chk("step lockout", su, 8'h00);
  endtask : t_step
  task automatic t_therm();
    put(11, 1'b1);
    chk("pause hot", cp, 8'h01);
    put(11, 1'b0);
    chk("pause off", cp, 8'h00);
    put(12, 1'b1);
    chk("pause cold", cp, 8'h01);
    put(7, 1'b1);
    chk("hot irq off", irq, 8'h00);
    chk("cond off", ce, 8'h00);
    put(14, 1'b1);
    chk("conditioner", ce, 8'h01);
  endtask : t_therm
  task automatic final_report();
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Main sequence after a three cycle reset
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_irq();
    t_step();
    t_therm();
    final_report();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule : testbench
